// ===== hdl/cphs_proc.sv
`include "cphs_defs.svh"

// Summary of operation
// - Disable processor port, select internal port
// - Enable gated clock, light LED 0
// - Grant only after request seen
// - Controller initializes then observes automatically
// - Uncorrectable error holds LED 4
// - Assert release, wait request drop
// - Controller drops request and idles in the same cycle
// - Then stop gated controller clock
// - Only then restore port, multiboot
// - Variant two: switch 1 blinks LED 1
// - Variant two: switch 2 alone chases LEDs 1-4
// - One internal port per controller
// - Configuration memory coverage only
// - Correction pulses LED 3 briefly
module cphs_proc (
    input wire logic clk,
    input wire logic resetn,
    cphs_if.proc link,
    input wire logic start,
    input wire logic reclaim,
    input wire logic variant2,
    input wire logic [1:0] user_sw,
    output logic proc_port_en,
    output logic internal_port_sel,
    output logic multiboot,
    output logic [`CPHS_LED_W-1:0] led
);

    typedef struct packed {
        cphs_pkg::cphs_proc_state_type st;
        logic proc_en;
        logic int_sel;
        logic clk_en;
        logic grant;
        logic rel;
        logic boot;
        logic [`CPHS_CNT_W-1:0] tick;
        logic [1:0] chase;
        logic blink;
    } cphs_proc_st_type;

    cphs_proc_st_type s_q;
    cphs_proc_st_type s_d;
    logic [`CPHS_LED_W-1:0] led_v;

    always_comb
    begin
        s_d = s_q;
        s_d.boot = 1'b0;
        case (s_q.st)
            cphs_pkg::CPHS_P_IDLE:
            begin
                if (start)
                begin
                    s_d.st = cphs_pkg::CPHS_P_SELECT;
                end
            end
            cphs_pkg::CPHS_P_SELECT:
            begin
                s_d.proc_en = 1'b0;
                s_d.int_sel = 1'b1;
                s_d.st = cphs_pkg::CPHS_P_CLK_ON;
            end
            cphs_pkg::CPHS_P_CLK_ON:
            begin
                s_d.clk_en = 1'b1;
                s_d.st = cphs_pkg::CPHS_P_WAIT_REQ;
            end
            cphs_pkg::CPHS_P_WAIT_REQ:
            begin
                if (link.port_request && !(variant2 && user_sw != 2'b00))
                begin
                    s_d.grant = 1'b1;
                    s_d.st = cphs_pkg::CPHS_P_OWNED;
                end
            end
            cphs_pkg::CPHS_P_OWNED:
            begin
                if (reclaim)
                begin
                    s_d.rel = 1'b1;
                    s_d.st = cphs_pkg::CPHS_P_RELEASE;
                end
            end
            cphs_pkg::CPHS_P_RELEASE:
            begin
                if (!link.port_request)
                begin
                    s_d.grant = 1'b0;
                    s_d.st = cphs_pkg::CPHS_P_CLK_OFF;
                end
            end
            cphs_pkg::CPHS_P_CLK_OFF:
            begin
                s_d.clk_en = 1'b0;
                s_d.rel = 1'b0;
                s_d.st = cphs_pkg::CPHS_P_REBOOT;
            end
            cphs_pkg::CPHS_P_REBOOT:
            begin
                s_d.proc_en = 1'b1;
                s_d.int_sel = 1'b0;
                s_d.boot = 1'b1;
                s_d.st = cphs_pkg::CPHS_P_IDLE;
            end
            default:
            begin
                s_d.st = cphs_pkg::CPHS_P_IDLE;
            end
        endcase
        // Blink and chase timebase
        if (s_q.tick == 8'(`CPHS_BLINK_CYC - 1))
        begin
            s_d.tick = 8'h00;
            s_d.blink = ~s_q.blink;
            s_d.chase = s_q.chase + 2'b01;
        end
        else
        begin
            s_d.tick = s_q.tick + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
            s_q.proc_en <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    always_comb
    begin
        led_v = '0;
        led_v[`CPHS_LED_CLK_EN] = s_q.clk_en;
        led_v[`CPHS_LED_REQ] = link.port_request;
        led_v[`CPHS_LED_REL] = s_q.rel;
        if (variant2 && s_q.clk_en)
        begin
            if (user_sw[0])
            begin
                led_v[`CPHS_LED_BLINK] = s_q.blink;
            end
            else if (user_sw[1])
            begin
                led_v[3'(`CPHS_LED_BLINK) + 3'(s_q.chase)] = 1'b1;
            end
        end
    end

    assign link.port_grant = s_q.grant;
    assign link.port_release = s_q.rel;
    assign link.clock_enable = s_q.clk_en;
    assign proc_port_en = s_q.proc_en;
    assign internal_port_sel = s_q.int_sel;
    assign multiboot = s_q.boot;
    assign led = led_v;

endmodule // cphs_proc

// ===== inc/cphs_defs.svh
`ifndef CPHS_DEFS_SVH
`define CPHS_DEFS_SVH

// Indicator LED positions
`define CPHS_LED_CLK_EN 0
`define CPHS_LED_BLINK 1
`define CPHS_LED_CORR 3
`define CPHS_LED_UNCORR 4
`define CPHS_LED_REQ 5
`define CPHS_LED_REL 7
`define CPHS_LED_W 8

// Timing in ns and derived counts at 25 MHz
`define CPHS_CLK_NS 40
`define CPHS_INIT_NS 400
`define CPHS_INIT_CYC ((`CPHS_INIT_NS + `CPHS_CLK_NS - 1) / `CPHS_CLK_NS)
`define CPHS_CORR_PULSE_NS 200
`define CPHS_CORR_PULSE_CYC (`CPHS_CORR_PULSE_NS / `CPHS_CLK_NS)
`define CPHS_BLINK_NS 1000
`define CPHS_BLINK_CYC (`CPHS_BLINK_NS / `CPHS_CLK_NS)
`define CPHS_CNT_W 8

`endif

// ===== inc/cphs_pkg.sv
package cphs_pkg;

    typedef enum logic [1:0] {
        CPHS_C_IDLE = 2'b00,
        CPHS_C_INIT = 2'b01,
        CPHS_C_OBSERVE = 2'b10
    } cphs_ctrl_state_type;

    typedef enum logic [2:0] {
        CPHS_P_IDLE = 3'b000,
        CPHS_P_SELECT = 3'b001,
        CPHS_P_CLK_ON = 3'b010,
        CPHS_P_WAIT_REQ = 3'b011,
        CPHS_P_OWNED = 3'b100,
        CPHS_P_RELEASE = 3'b101,
        CPHS_P_CLK_OFF = 3'b110,
        CPHS_P_REBOOT = 3'b111
    } cphs_proc_state_type;

endpackage

// ===== inc/cphs_if.sv
interface cphs_if;
    logic port_request;
    logic port_grant;
    logic port_release;
    logic clock_enable;

    modport ctrl (
        output port_request,
        input port_grant,
        input port_release,
        input clock_enable
    );

    modport proc (
        input port_request,
        output port_grant,
        output port_release,
        output clock_enable
    );
endinterface

// ===== hdl/cphs_ctrl.sv
`include "cphs_defs.svh"

module cphs_ctrl (
    input wire logic clk,
    input wire logic resetn,
    cphs_if.ctrl link,
    input wire logic err_detect,
    input wire logic err_correctable,
    output logic led_corrected,
    output logic led_uncorrectable,
    output logic observing,
    output logic idle
);

    typedef struct packed {
        cphs_pkg::cphs_ctrl_state_type st;
        logic req;
        logic [`CPHS_CNT_W-1:0] cnt;
        logic [`CPHS_CNT_W-1:0] pulse;
        logic uncorr;
    } cphs_ctrl_st_type;

    cphs_ctrl_st_type s_q;
    cphs_ctrl_st_type s_d;

    always_comb
    begin
        s_d = s_q;
        // Counting and scanning only while the gated clock is enabled
        if (link.clock_enable)
        begin
            if (s_q.pulse != 8'h00)
            begin
                s_d.pulse = s_q.pulse - 8'h01;
            end
            case (s_q.st)
                cphs_pkg::CPHS_C_IDLE:
                begin
                    s_d.req = 1'b1;
                    if (link.port_grant && s_q.req && !link.port_release)
                    begin
                        s_d.st = cphs_pkg::CPHS_C_INIT;
                        s_d.cnt = 8'h00;
                    end
                end
                cphs_pkg::CPHS_C_INIT:
                begin
                    if (s_q.cnt == 8'(`CPHS_INIT_CYC - 1))
                    begin
                        s_d.st = cphs_pkg::CPHS_C_OBSERVE;
                    end
                    else
                    begin
                        s_d.cnt = s_q.cnt + 8'h01;
                    end
                end
                cphs_pkg::CPHS_C_OBSERVE:
                begin
                    if (err_detect && err_correctable)
                    begin
                        s_d.pulse = 8'(`CPHS_CORR_PULSE_CYC);
                    end
                    if (err_detect && !err_correctable)
                    begin
                        s_d.uncorr = 1'b1;
                    end
                end
                default:
                begin
                    s_d.st = cphs_pkg::CPHS_C_IDLE;
                end
            endcase
            if (link.port_release && s_q.st != cphs_pkg::CPHS_C_IDLE)
            begin
                s_d.req = 1'b0;
                s_d.st = cphs_pkg::CPHS_C_IDLE;
            end
            else if (link.port_release)
            begin
                s_d.req = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign link.port_request = s_q.req;
    assign led_corrected = (s_q.pulse != 8'h00);
    assign led_uncorrectable = s_q.uncorr;
    assign observing = (s_q.st == cphs_pkg::CPHS_C_OBSERVE);
    assign idle = (s_q.st == cphs_pkg::CPHS_C_IDLE);

endmodule // cphs_ctrl

// ===== tb/cphs_handoff_asserts.sv
module cphs_handoff_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire logic port_request,
    input wire logic port_grant,
    input wire logic port_release,
    input wire logic clock_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Request drops, then grant, then clock and release together
    sequence s_drop;
        !port_request ##1 !port_grant ##1 (!clock_enable && !port_release);
    endsequence
    property p_release_seq;
        $rose(port_release) |-> ##1 s_drop;
    endproperty
    a_release_seq: assert property (p_release_seq) else $error("release sequence broken");
    property p_grant_after_req;
        $rose(port_grant) |-> $past(port_request);
    endproperty
    a_grant_after_req: assert property (p_grant_after_req) else $error("grant without request");
    property p_clk_before_req;
        $rose(port_request) |-> $past(clock_enable);
    endproperty
    a_clk_before_req: assert property (p_clk_before_req) else $error("request before clock");
    property p_req_needs_clk;
        port_request |-> clock_enable;
    endproperty
    a_req_needs_clk: assert property (p_req_needs_clk) else $error("request without clock");
    property p_clk_off_last;
        $fell(clock_enable) |-> !port_grant && !port_request;
    endproperty
    a_clk_off_last: assert property (p_clk_off_last) else $error("clock stopped early");
    property p_req_drop_cause;
        $fell(port_request) |-> $past(port_release);
    endproperty
    a_req_drop_cause: assert property (p_req_drop_cause) else $error("request dropped alone");
    property p_grant_held;
        $fell(port_grant) |-> $past(port_release, 2);
    endproperty
    a_grant_held: assert property (p_grant_held) else $error("grant dropped early");
    property p_owned_keeps_req;
        port_grant && !port_release |-> port_request;
    endproperty
    a_owned_keeps_req: assert property (p_owned_keeps_req) else $error("owner lost request");
endmodule // cphs_handoff_asserts

// ===== tb/testbench.sv
`include "cphs_defs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, resetn = 0, start = 0, reclaim = 0, variant2 = 0;
    logic err_detect = 0, err_correctable = 0;
    logic [1:0] user_sw = 2'h0;
    logic led_corrected, led_uncorrectable, observing, idle;
    logic proc_port_en, internal_port_sel, multiboot;
    logic [7:0] led;
    int error_cnt = 0, compares = 0, cycles = 0, n;
    cphs_if bus ();
    cphs_ctrl cphs_ctrl_i (.clk(clk), .resetn(resetn), .link(bus), .err_detect(err_detect),
        .err_correctable(err_correctable), .led_corrected(led_corrected),
        .led_uncorrectable(led_uncorrectable), .observing(observing), .idle(idle));
    cphs_proc cphs_proc_i (.clk(clk), .resetn(resetn), .link(bus), .start(start),
        .reclaim(reclaim), .variant2(variant2), .user_sw(user_sw), .proc_port_en(proc_port_en),
        .internal_port_sel(internal_port_sel), .multiboot(multiboot), .led(led));
    cphs_handoff_asserts cphs_handoff_asserts_i (.clk(clk), .resetn(resetn),
        .port_request(bus.port_request), .port_grant(bus.port_grant),
        .port_release(bus.port_release), .clock_enable(bus.clock_enable));

    always #20 clk = ~clk;

    task automatic tally_and_finish();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] led_exp(logic ce, logic req, logic rel);
        return {rel, 1'b0, req, 4'h0, ce};
    endfunction

    function automatic logic sel(int w);
        case (w)
            0: return bus.clock_enable;
            1: return bus.port_grant;
            2: return observing;
            3: return idle;
            4: return multiboot;
            default: return led_corrected;
        endcase
    endfunction

    // Bounded wait on a chosen status, sampled mid-cycle
    task automatic wait_for(int w);
        n = 0;
        @(negedge clk);
        while (sel(w) !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    // Raise one strobe for a single cycle: 0 start, 1 reclaim, 2 error
    task automatic pulse(int which);
        @(posedge clk)
        begin
            start <= (which == 0);
            reclaim <= (which == 1);
            err_detect <= (which == 2);
        end
        @(posedge clk)
        begin
            start <= 1'b0;
            reclaim <= 1'b0;
            err_detect <= 1'b0;
        end
    endtask

    task automatic error(logic corr);
        @(posedge clk) err_correctable <= corr;
        pulse(2);
    endtask

    function automatic logic [3:0] next_chase(logic [3:0] p);
        return {p[2:0], p[3]};
    endfunction

    // Switches held: LEDs 1-4 show the pattern and grant stays withheld
    task automatic sw_phase(logic [1:0] sw);
        logic [3:0] prev;
        int moves;
        @(posedge clk) user_sw <= sw;
        @(negedge clk);
        prev = led[4:1];
        moves = 0;
        repeat (30 + $urandom_range(10))
        begin
            @(negedge clk);
            if (sw[0])
                chk("blink", {5'h0, led[4:2]}, 8'h00);
            else
                chk("chase", {7'h0, $countones(led[4:1]) == 1}, 8'h01);
            if (led[4:1] != prev)
            begin
                moves++;
                if (!sw[0])
                    chk("step", {4'h0, led[4:1]}, {4'h0, next_chase(prev)});
            end
            prev = led[4:1];
        end
        chk("moves", {7'h0, moves != 0}, 8'h01);
        chk("refused", {7'h0, bus.port_grant}, 8'h00);
    endtask

    task automatic handoff(logic v2, logic [1:0] sw);
        @(posedge clk)
        begin
            variant2 <= v2;
            user_sw <= v2 ? 2'h0 : sw;
        end
        pulse(0);
        wait_for(0);
        chk("clk_on", {7'h0, bus.clock_enable}, 8'h01);
        chk("sel", {6'h0, proc_port_en, internal_port_sel}, 8'h01);
        if (v2)
        begin
            sw_phase(2'h1);
            sw_phase(2'h2);
            sw_phase(sw);
            @(posedge clk) user_sw <= 2'h0;
        end
        wait_for(1);
        chk("grant", {7'h0, bus.port_grant}, 8'h01);
        wait_for(2);
        chk("observe", {7'h0, observing}, 8'h01);
        chk("led", led, led_exp(1'b1, 1'b1, 1'b0));
    endtask

    task automatic reclaim_port();
        pulse(1);
        @(negedge clk);
        chk("rel", led, led_exp(1'b1, 1'b1, 1'b1));
        wait_for(3);
        chk("idle", {7'h0, idle}, 8'h01);
        wait_for(4);
        chk("boot", {7'h0, multiboot}, 8'h01);
        chk("path", {5'h0, proc_port_en, internal_port_sel, bus.clock_enable}, 8'h04);
        chk("ledoff", led, led_exp(1'b0, 1'b0, 1'b0));
        @(negedge clk);
        chk("boot_end", {7'h0, multiboot}, 8'h00);
    endtask

    initial
    begin
        void'($urandom(32'hF2E59CA9));
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        error(1'b0);
        repeat (3) @(negedge clk);
        chk("early", {7'h0, led_uncorrectable}, 8'h00);
        handoff(1'b0, 2'($urandom_range(3)));
        repeat (1 + $urandom_range(3))
        begin
            repeat ($urandom_range(8)) @(posedge clk);
            error(1'b1);
            wait_for(5);
            chk("corr_on", {7'h0, led_corrected}, 8'h01);
            n = 0;
            while (led_corrected === 1'b1 && n < 50)
            begin
                @(negedge clk);
                n++;
            end
            chk("corr", n[7:0], 8'(`CPHS_CORR_PULSE_CYC));
        end
        error(1'b0);
        repeat (3) @(negedge clk);
        chk("unc", {7'h0, led_uncorrectable}, 8'h01);
        reclaim_port();
        handoff(1'b1, 2'(1 + $urandom_range(2)));
        reclaim_port();
        chk("sticky", {7'h0, led_uncorrectable}, 8'h01);
        // Reconfiguration modelled as a reset clears the sticky flag
        @(posedge clk) resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk("reconf", {6'h0, led_uncorrectable, proc_port_en}, 8'h01);
        tally_and_finish();
    end
endmodule // testbench
